/* File: rtl/psw_defines.vh */
// Constants shared by the status word block and its flag calculator.
`ifndef PSW_DEFINES_VH
`define PSW_DEFINES_VH

`define PSW_ADDR 8'hd0
`define RESULT_ADDR 8'hd4
`define PSW_RESET 8'h00
`define RESULT_RESET 8'h00

`define PSW_BIT_CY 7
`define PSW_BIT_AC 6
`define PSW_BIT_F0 5
`define PSW_BIT_RS_HI 4
`define PSW_BIT_RS_LO 3
`define PSW_BIT_OV 2
`define PSW_BIT_F1 1
`define PSW_BIT_P 0

`define ALU_ADD 3'h0
`define ALU_ADDC 3'h1
`define ALU_SUBB 3'h2
`define ALU_RLC 3'h3
`define ALU_RRC 3'h4
`define ALU_CMP 3'h5
`define ALU_DA 3'h6
`define ALU_PASS 3'h7

`define BIT_CLR 3'h0
`define BIT_SET 3'h1
`define BIT_CPL 3'h2
`define BIT_AND 3'h3
`define BIT_OR 3'h4
`define BIT_ANDN 3'h5
`define BIT_ORN 3'h6
`define BIT_MOV 3'h7

`endif

/* File: rtl/alu_flag_calc.v */
// Combinational ALU result and flag calculation for the status word.
`timescale 1ns/100ps
`include "psw_defines.vh"

module alu_flag_calc (
  input wire [2:0] op_i,
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire cy_i,
  input wire ac_i,
  output reg [7:0] res_o,
  output reg cy_o,
  output reg ac_o,
  output reg ov_o,
  output reg upd_cy_o,
  output reg upd_ac_o,
  output reg upd_ov_o
);

  reg cin;
  reg [8:0] wide;
  reg [4:0] low;
  reg [8:0] adj;

  always @* begin
    cin = 1'b0;
    wide = 9'h000;
    low = 5'h00;
    adj = {1'b0, a_i};
    res_o = a_i;
    cy_o = cy_i;
    ac_o = ac_i;
    ov_o = 1'b0;
    upd_cy_o = 1'b0;
    upd_ac_o = 1'b0;
    upd_ov_o = 1'b0;
    case (op_i)
      `ALU_ADD, `ALU_ADDC: begin
        cin = (op_i == `ALU_ADDC) ? cy_i : 1'b0;
        wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin};
        low = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin};
        res_o = wide[7:0];
        cy_o = wide[8];
        ac_o = low[4];
        // Carry out of bit six xor bit seven.
        ov_o = (a_i[7] == b_i[7]) && (wide[7] != a_i[7]);
        upd_cy_o = 1'b1;
        upd_ac_o = 1'b1;
        upd_ov_o = 1'b1;
      end
      `ALU_SUBB: begin
        wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cy_i};
        low = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cy_i};
        res_o = wide[7:0];
        cy_o = wide[8];
        ac_o = low[4];
        ov_o = (a_i[7] != b_i[7]) && (wide[7] != a_i[7]);
        upd_cy_o = 1'b1;
        upd_ac_o = 1'b1;
        upd_ov_o = 1'b1;
      end
      `ALU_RLC: begin
        res_o = {a_i[6:0], cy_i};
        cy_o = a_i[7];
        upd_cy_o = 1'b1;
      end
      `ALU_RRC: begin
        res_o = {cy_i, a_i[7:1]};
        cy_o = a_i[0];
        upd_cy_o = 1'b1;
      end
      `ALU_CMP: begin
        cy_o = (a_i < b_i);
        upd_cy_o = 1'b1;
      end
      `ALU_DA: begin
        if (ac_i || (a_i[3:0] > 4'h9)) begin
          adj = adj + 9'h006;
        end
        if (cy_i || adj[8] || (adj[7:4] > 4'h9)) begin
          adj = adj + 9'h060;
        end
        res_o = adj[7:0];
        // Decimal adjust can only set carry, never clear it.
        cy_o = cy_i | adj[8];
        upd_cy_o = 1'b1;
      end
      default: begin
        res_o = a_i;
      end
    endcase
  end

endmodule

/* File: rtl/status_word_flags.v */
// Status word: ALU flags, user flags, bank select and parity, on Wishbone.
//
// Our own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "psw_defines.vh"

module status_word_flags #(
  parameter ADDR_W = 8,
  parameter DATA_W = 32
) (
  input wire clk_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] adr_i,
  input wire [DATA_W-1:0] dat_i,
  output reg [DATA_W-1:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  input wire [7:0] acc_i,
  input wire alu_valid_i,
  input wire [2:0] alu_op_i,
  input wire [7:0] alu_a_i,
  input wire [7:0] alu_b_i,
  input wire bit_valid_i,
  input wire [2:0] bit_op_i,
  input wire bit_val_i,
  input wire [2:0] reg_idx_i,
  output reg [7:0] alu_result_o,
  output reg [7:0] psw_o,
  output reg carry_o,
  output reg [4:0] wreg_addr_o
);

  reg cy_q;
  reg ac_q;
  reg f0_q;
  reg [1:0] bank_q;
  reg ov_q;
  reg f1_q;
  reg p_q;
  reg [7:0] result_q;

  reg cy_d;
  reg ac_d;
  reg f0_d;
  reg [1:0] bank_d;
  reg ov_d;
  reg f1_d;

  wire bus_req;
  wire bus_wr;
  wire psw_wr;
  wire [7:0] psw_now;

  wire [7:0] calc_res;
  wire calc_cy;
  wire calc_ac;
  wire calc_ov;
  wire upd_cy;
  wire upd_ac;
  wire upd_ov;

  // Address match against one register word; used for reads and writes.
  function hit;
    input [ADDR_W-1:0] adr;
    input [7:0] reg_addr;
    begin
      hit = (adr[7:2] == reg_addr[7:2]);
    end
  endfunction

  // Boolean operation with the carry as the one-bit accumulator.
  function bit_calc;
    input [2:0] op;
    input cy;
    input val;
    begin
      case (op)
        `BIT_CLR: bit_calc = 1'b0;
        `BIT_SET: bit_calc = 1'b1;
        `BIT_CPL: bit_calc = ~cy;
        `BIT_AND: bit_calc = cy & val;
        `BIT_OR: bit_calc = cy | val;
        `BIT_ANDN: bit_calc = cy & ~val;
        `BIT_ORN: bit_calc = cy | ~val;
        default: bit_calc = val;
      endcase
    end
  endfunction

  alu_flag_calc u_calc (
    .op_i(alu_op_i),
    .a_i(alu_a_i),
    .b_i(alu_b_i),
    .cy_i(cy_q),
    .ac_i(ac_q),
    .res_o(calc_res),
    .cy_o(calc_cy),
    .ac_o(calc_ac),
    .ov_o(calc_ov),
    .upd_cy_o(upd_cy),
    .upd_ac_o(upd_ac),
    .upd_ov_o(upd_ov)
  );

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign bus_wr = bus_req & we_i & sel_i[0];
  assign psw_wr = bus_wr & hit(adr_i, `PSW_ADDR);
  assign psw_now = {cy_q, ac_q, f0_q, bank_q, ov_q, f1_q, p_q};

  // Bus write first, then datapath updates, so a hardware event in the
  // same cycle as a software write is never lost.
  always @* begin
    cy_d = cy_q;
    ac_d = ac_q;
    f0_d = f0_q;
    bank_d = bank_q;
    ov_d = ov_q;
    f1_d = f1_q;
    if (psw_wr) begin
      cy_d = dat_i[`PSW_BIT_CY];
      ac_d = dat_i[`PSW_BIT_AC];
      f0_d = dat_i[`PSW_BIT_F0];
      f1_d = dat_i[`PSW_BIT_F1];
      bank_d = dat_i[`PSW_BIT_RS_HI:`PSW_BIT_RS_LO];
      ov_d = dat_i[`PSW_BIT_OV];
    end
    if (alu_valid_i) begin
      if (upd_cy) begin
        cy_d = calc_cy;
      end
      if (upd_ac) begin
        ac_d = calc_ac;
      end
      if (upd_ov) begin
        ov_d = calc_ov;
      end
    end else if (bit_valid_i) begin
      cy_d = bit_calc(bit_op_i, cy_q, bit_val_i);
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      cy_q <= 1'b0;
      ac_q <= 1'b0;
      f0_q <= 1'b0;
      bank_q <= 2'h0;
      ov_q <= 1'b0;
      f1_q <= 1'b0;
      p_q <= 1'b0;
      result_q <= `RESULT_RESET;
    end else begin
      cy_q <= cy_d;
      ac_q <= ac_d;
      f0_q <= f0_d;
      bank_q <= bank_d;
      ov_q <= ov_d;
      f1_q <= f1_d;
      p_q <= ^acc_i;
      if (alu_valid_i) begin
        result_q <= calc_res;
      end
    end
  end

  // Outputs are registered copies, so they lag the flags by one cycle.
  always @(posedge clk_i) begin
    if (rst_i) begin
      alu_result_o <= `RESULT_RESET;
      psw_o <= `PSW_RESET;
      carry_o <= 1'b0;
      wreg_addr_o <= 5'h00;
    end else begin
      alu_result_o <= result_q;
      psw_o <= psw_now;
      carry_o <= cy_q;
      wreg_addr_o <= {bank_q, reg_idx_i};
    end
  end

  // Single wait-free answer: ack one cycle after the request, then low.
  // Unmapped addresses are acknowledged and read as zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= {DATA_W{1'b0}};
    end else begin
      ack_o <= bus_req;
      dat_o <= {DATA_W{1'b0}};
      if (bus_req && !we_i) begin
        if (hit(adr_i, `PSW_ADDR)) begin
          dat_o <= {{(DATA_W-8){1'b0}}, psw_now};
        end else if (hit(adr_i, `RESULT_ADDR)) begin
          dat_o <= {{(DATA_W-8){1'b0}}, result_q};
        end
      end
    end
  end

endmodule

/* File: dv/exec_model.sv */
// Execution datapath model that issues one ALU operation at a time.
`timescale 1ns/100ps
module exec_model (
  input wire clk_i,
  output logic valid_o,
  output logic [2:0] op_o,
  output logic [7:0] a_o,
  output logic [7:0] b_o
);
  initial {valid_o, op_o, a_o, b_o} = '0;
  task automatic issue(input [2:0] op, input [7:0] a, input [7:0] b);
    @(posedge clk_i);
    valid_o <= 1'b1;
    op_o <= op;
    a_o <= a;
    b_o <= b;
    @(posedge clk_i);
    valid_o <= 1'b0;
    // Operands are stale after the pulse, so they are scrambled, not held.
    a_o <= ~a;
    b_o <= ~b;
  endtask
endmodule

/* File: dv/psw_monitor.sv */
// Checker on the status word block ports.
`timescale 1ns/100ps
`include "psw_defines.vh"
module psw_monitor #(parameter ADDR_W = 8, parameter DATA_W = 32) (
  input wire clk_i, rst_i, we_i, cyc_i, stb_i, ack_o, alu_valid_i, bit_valid_i, bit_val_i, carry_o,
  input wire [ADDR_W-1:0] adr_i,
  input wire [DATA_W-1:0] dat_i, dat_o,
  input wire [3:0] sel_i,
  input wire [2:0] alu_op_i, bit_op_i, reg_idx_i,
  input wire [7:0] acc_i, alu_a_i, alu_b_i, alu_result_o, psw_o,
  input wire [4:0] wreg_addr_o
);
  logic [1:0] rc_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Edges since reset, so history from inside reset is never used.
  always @(posedge clk_i) begin
    if (rst_i) rc_q <= 2'd0;
    else if (rc_q != 2'd3) rc_q <= rc_q + 2'd1;
  end
  sequence add_op;
    alu_valid_i && alu_op_i == `ALU_ADD;
  endsequence
  chk_ack_after_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  chk_ack_single: assert property (ack_o |=> !ack_o) else $error("long ack");
  chk_write_value: assert property (ack_o && we_i && sel_i[0] && adr_i == `PSW_ADDR
    |=> {psw_o[5:3], psw_o[1]} == $past({dat_i[5:3], dat_i[1]})) else $error("write lost");
  chk_user_stable: assert property (!$past(ack_o) |-> $stable({psw_o[5], psw_o[1]})) else $error("user flag moved");
  chk_parity_acc: assert property (rc_q == 2'd3 |-> psw_o[0] == ^$past(acc_i, 2)) else $error("bad parity");
  chk_carry_copy: assert property (carry_o == psw_o[7]) else $error("carry copy");
  chk_bank_addr: assert property (rc_q != 2'd0 |-> wreg_addr_o == {psw_o[4:3], $past(reg_idx_i)})
    else $error("bank address");
  chk_add_carry: assert property (add_op |-> ##2 carry_o == ($past(alu_a_i, 2) + $past(alu_b_i, 2) > 9'hff))
    else $error("add carry");
  chk_add_half: assert property (add_op |-> ##2 psw_o[6] == ($past(alu_a_i[3:0], 2) + $past(alu_b_i[3:0], 2) > 5'hf))
    else $error("half carry");
endmodule
bind status_word_flags psw_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) mon (.*);

/* File: dv/tb.sv */
// Self-checking bench for the status word block.
`timescale 1ns/100ps
`include "psw_defines.vh"
module tb;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, bit_valid_i = 0, bit_val_i = 0;
  logic [7:0] adr_i = 0, acc_i = 0, rd, d, alu_a_i, alu_b_i, alu_result_o, psw_o;
  logic [31:0] dat_i = 0, dat_o, r, seed = 32'hde14;
  logic [3:0] sel_i = 4'hf;
  logic [2:0] bit_op_i = 0, reg_idx_i = 0, alu_op_i, op3, e;
  logic [7:0] res;
  logic ack_o, alu_valid_i, carry_o, v, c;
  logic [4:0] wreg_addr_o;
  int fails = 0, checks = 0, cyc_n = 0;
  status_word_flags dut (.*);
  exec_model px (.clk_i(clk_i), .valid_o(alu_valid_i), .op_o(alu_op_i), .a_o(alu_a_i), .b_o(alu_b_i));
  initial forever #25 clk_i = ~clk_i;
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [2:0] addf(input [7:0] a, input [7:0] b);
    logic [8:0] s;
    s = a + b;
    return {s[8], 5'(a[3:0]) + b[3:0] > 5'hf, a[7] == b[7] && s[7] != a[7]};
  endfunction
  // Subtract with borrow: carry and half carry hold the borrows.
  function logic [2:0] subf(input [7:0] a, input [7:0] b, input c0);
    logic [8:0] s;
    s = {1'b0, a} - {1'b0, b} - c0;
    return {s[8], 5'(a[3:0]) - b[3:0] - c0 > 5'hf, a[7] != b[7] && s[7] != a[7]};
  endfunction
  function logic bitf(input [2:0] op, input c0, input v0);
    logic [7:0] t;
    t = {v0, c0 | ~v0, c0 & ~v0, c0 | v0, c0 & v0, ~c0, 1'b1, 1'b0};
    return t[op];
  endfunction
  task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wb(input w, input [7:0] a, input [7:0] dd);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, 24'h0, dd};
    @(posedge clk_i);
    while (ack_o !== 1'b1) @(posedge clk_i);
    rd = dat_o[7:0];
    {cyc_i, stb_i, we_i} <= 3'b000;
  endtask
  task end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // A hang is cut short well beyond the 150 or so cycles needed.
  always @(posedge clk_i) if (++cyc_n == 5000) begin
    fails++;
    end_sim();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(0, `PSW_ADDR, 0);
    chk("reset", `PSW_RESET, rd);
    wb(1, 8'h10, 8'hff);
    wb(0, 8'h10, 0);
    chk("unmapped", 8'h00, rd);
    for (int i = 0; i < 8; i++) begin
      r = xs();
      d = {r[7:5], i[1:0], r[2:0]};
      acc_i <= r[15:8];
      reg_idx_i <= r[18:16];
      wb(1, `PSW_ADDR, d);
      wb(0, `PSW_ADDR, 0);
      chk("psw", {d[7:1], ^r[15:8]}, rd);
      chk("wreg", {d[4:3], r[18:16]}, wreg_addr_o);
    end
    // A write without the low byte select must leave the word alone.
    sel_i <= 4'he;
    wb(1, `PSW_ADDR, ~d);
    sel_i <= 4'hf;
    wb(0, `PSW_ADDR, 0);
    chk("masked", {d[7:1], ^acc_i}, rd);
    c = d[7];
    for (int i = 0; i < 10; i++) begin
      r = i == 0 ? 32'h017f : i == 1 ? 32'h01ff : xs();
      op3 = (i > 1 && r[16]) ? `ALU_SUBB : `ALU_ADD;
      e = op3 == `ALU_SUBB ? subf(r[7:0], r[15:8], c) : addf(r[7:0], r[15:8]);
      res = op3 == `ALU_SUBB ? r[7:0] - r[15:8] - c : r[7:0] + r[15:8];
      px.issue(op3, r[7:0], r[15:8]);
      repeat (2) @(posedge clk_i);
      c = e[2];
      chk("flags", {e, d[5], d[1]}, {psw_o[7:6], psw_o[2], psw_o[5], psw_o[1]});
      chk("result", res, alu_result_o);
    end
    for (int op = 0; op < 8; op++) begin
      v = r[op];
      @(posedge clk_i);
      {bit_valid_i, bit_op_i, bit_val_i} <= {1'b1, op[2:0], v};
      @(posedge clk_i);
      {bit_valid_i, bit_val_i} <= {1'b0, ~v};
      repeat (2) @(posedge clk_i);
      c = bitf(op[2:0], c, v);
      chk("carry", c, carry_o);
    end
    wb(0, `RESULT_ADDR, 0);
    chk("result reg", res, rd);
    end_sim();
  end
endmodule
